// *** logic/hlif_fifo.sv ***
// Small FIFO for one channel's outgoing bytes, width and depth as parameters.
// Assumes one clock, asynchronous active-high reset, DEPTH a power of two.
`timescale 1ns/1ps
module hlif_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Filling side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Draining side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic full;
        logic empty;
    } hlif_fifo_s;

    hlif_fifo_s state_r;
    hlif_fifo_s state_nxt;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic push;
    logic pull;

    // ==========================================================
    // Pointers and flags
    assign push = in_valid & ~state_r.full;
    assign pull = out_ready & ~state_r.empty;

    always_comb begin
        state_nxt = state_r;
        if (push) begin
            state_nxt.wp = state_r.wp + 1'b1;
        end
        if (pull) begin
            state_nxt.rp = state_r.rp + 1'b1;
        end
        case ({push, pull})
            2'b10: state_nxt.cnt = state_r.cnt + 1'b1;
            2'b01: state_nxt.cnt = state_r.cnt - 1'b1;
            default: state_nxt.cnt = state_r.cnt;
        endcase
        // Flags kept as flops so the ready seen upstream is clean
        state_nxt.full = (state_nxt.cnt == (AW+1)'(DEPTH));
        state_nxt.empty = (state_nxt.cnt == '0);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= '{wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Storage; no reset needed on data words
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_r[state_r.wp] <= in_data;
        end
    end

    assign out_data = mem_r[state_r.rp];
    assign out_valid = ~state_r.empty;
    assign in_ready = ~state_r.full;
endmodule

// *** logic/hlif_line_top.sv ***
// Constants, types and line-side logic of a two-channel HDLC line interface.
// Assumes pin inputs already synchronous to core_clk; no software registers.
`timescale 1ns/1ps
package hlif_pkg;
    localparam int NCH = 2;
    localparam int BYTE_W = 8;
    localparam int QUEUE_DEPTH = 4;
    localparam logic [7:0] FLAG_OCTET = 8'h7E;
    localparam logic [7:0] BAUD_HALF_DIV = 8'h08;
    localparam logic [3:0] LOAD_BITS = 4'h7;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [1:0] {CODE_NRZ, CODE_NRZI, CODE_FM, CODE_MAN} hlif_code_e;
    typedef enum logic [1:0] {MON_TX, MON_RX, MON_BAUD} hlif_mon_e;

    typedef struct packed {
        hlif_code_e coding;
        logic rx_pin_clk;
        logic baud_from_rx;
        logic tx_clk_ext;
        logic mon_en;
        hlif_mon_e mon_sel;
        logic term_ready;
    } hlif_cfg_s;

    typedef struct packed {
        logic permit;
        logic carrier;
    } hlif_chg_s;

    typedef struct packed {
        logic rxc_q;
        logic txc_q;
        logic [7:0] div;
        logic half;
        logic baud_tog;
        logic [7:0] tx_sh;
        logic [3:0] tx_cnt;
        logic tx_bit;
        logic tx_line;
        logic tx_clk_tog;
        logic rts_n;
        logic dtr_n;
        logic rx_phase;
        logic rx_half;
        logic rx_prev;
        logic [7:0] rx_sh;
        logic [2:0] rx_cnt;
        logic [7:0] hist;
        logic [7:0] rx_byte;
        logic rx_valid;
        logic sync_n;
        logic cts_q;
        logic dcd_q;
        hlif_chg_s chg;
        logic txc_o;
        logic txc_oe;
    } hlif_chan_s;

    localparam hlif_chan_s CHAN_RST = '{rts_n: 1'b1, dtr_n: 1'b1, tx_bit: 1'b1, tx_line: 1'b1,
        rx_prev: 1'b1, sync_n: 1'b1, cts_q: 1'b1, dcd_q: 1'b1, default: '0};
endpackage

module hlif_line_top import hlif_pkg::*; #(
    parameter logic [7:0] BAUD_DIV = BAUD_HALF_DIV
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Channel A user side
    input wire hlif_cfg_s cfg_a,
    input wire logic [BYTE_W-1:0] tx_byte_a,
    input wire logic tx_valid_a,
    output logic tx_ready_a,
    output logic [BYTE_W-1:0] rx_byte_a,
    output logic rx_valid_a,
    output hlif_chg_s changed_a,
    input wire hlif_chg_s change_clear_a,
    // Channel A line pins
    output logic line_tx_data_a,
    input wire logic line_rx_data_a,
    output logic terminal_ready_n_a,
    output logic send_request_n_a,
    input wire logic send_permit_n_a,
    input wire logic carrier_present_n_a,
    output logic flag_seen_n_a,
    input wire logic line_rx_clock_a,
    input wire logic line_tx_clock_a_i,
    output logic line_tx_clock_a_o,
    output logic line_tx_clock_a_oe,
    // Channel B user side
    input wire hlif_cfg_s cfg_b,
    input wire logic [BYTE_W-1:0] tx_byte_b,
    input wire logic tx_valid_b,
    output logic tx_ready_b,
    output logic [BYTE_W-1:0] rx_byte_b,
    output logic rx_valid_b,
    output hlif_chg_s changed_b,
    input wire hlif_chg_s change_clear_b,
    // Channel B line pins
    output logic line_tx_data_b,
    input wire logic line_rx_data_b,
    output logic terminal_ready_n_b,
    output logic send_request_n_b,
    input wire logic send_permit_n_b,
    input wire logic carrier_present_n_b,
    output logic flag_seen_n_b,
    input wire logic line_rx_clock_b,
    input wire logic line_tx_clock_b_i,
    output logic line_tx_clock_b_o,
    output logic line_tx_clock_b_oe
);
    hlif_chan_s state_r [NCH];
    hlif_chan_s state_nxt [NCH];
    hlif_cfg_s cfg [NCH];
    hlif_chg_s clr [NCH];
    logic [BYTE_W-1:0] wr_byte [NCH];
    logic [BYTE_W-1:0] q_data [NCH];
    logic [NCH-1:0] wr_valid, wr_ready, q_valid;
    logic [NCH-1:0] rxd, rxc, txc, permit_n, carrier_n;
    logic [NCH-1:0] pop, b0_ev, bit_ev, flag_hit;

    // ==========================================================
    // Per-channel views of the pins
    assign cfg[0] = cfg_a;
    assign cfg[1] = cfg_b;
    assign clr[0] = change_clear_a;
    assign clr[1] = change_clear_b;
    assign wr_byte[0] = tx_byte_a;
    assign wr_byte[1] = tx_byte_b;
    assign wr_valid = {tx_valid_b, tx_valid_a};
    assign rxd = {line_rx_data_b, line_rx_data_a};
    assign rxc = {line_rx_clock_b, line_rx_clock_a};
    assign txc = {line_tx_clock_b_i, line_tx_clock_a_i};
    assign permit_n = {send_permit_n_b, send_permit_n_a};
    assign carrier_n = {carrier_present_n_b, carrier_present_n_a};

    // ==========================================================
    // Transmit queues, one per channel
    for (genvar q = 0; q < NCH; q++) begin : g_queue
        hlif_fifo #(.WIDTH(BYTE_W), .DEPTH(QUEUE_DEPTH)) u_queue (
            .core_clk(core_clk),
            .rst(rst),
            .in_data(wr_byte[q]),
            .in_valid(wr_valid[q]),
            .in_ready(wr_ready[q]),
            .out_data(q_data[q]),
            .out_valid(q_valid[q]),
            .out_ready(pop[q])
        );
    end

    // ==========================================================
    // Channel logic; the loop gives B the same behaviour as A
    always_comb begin
        hlif_chan_s n;
        logic tick, rx_rise, tx_rise, tx_fall, mid, samp, bitv, dbit;
        n = '0;
        tick = 1'b0;
        rx_rise = 1'b0;
        tx_rise = 1'b0;
        tx_fall = 1'b0;
        mid = 1'b0;
        samp = 1'b0;
        bitv = 1'b0;
        dbit = 1'b0;
        pop = '0;
        b0_ev = '0;
        bit_ev = '0;
        flag_hit = '0;
        for (int c = 0; c < NCH; c++) begin
            n = state_r[c];
            rx_rise = rxc[c] & ~state_r[c].rxc_q;
            tx_rise = txc[c] & ~state_r[c].txc_q;
            tx_fall = ~txc[c] & state_r[c].txc_q;
            n.rxc_q = rxc[c];
            n.txc_q = txc[c];

            // Baud generator, fed by core clock or receive clock pin
            tick = 1'b0;
            if (!cfg[c].baud_from_rx || rx_rise) begin
                if (state_r[c].div == 8'h00) begin
                    n.div = BAUD_DIV - 8'h01;
                    tick = 1'b1;
                    n.half = ~state_r[c].half;
                    n.baud_tog = ~state_r[c].baud_tog;
                end else begin
                    n.div = state_r[c].div - 8'h01;
                end
            end

            // Bit boundary on falling edge of external transmit clock
            b0_ev[c] = cfg[c].tx_clk_ext ? tx_fall : (tick & ~state_r[c].half);
            mid = cfg[c].tx_clk_ext ? tx_rise : (tick & state_r[c].half);
            bitv = state_r[c].tx_bit;
            if (b0_ev[c]) begin
                if (state_r[c].tx_cnt != 4'h0) begin
                    bitv = state_r[c].tx_sh[0];
                    n.tx_sh = {1'b0, state_r[c].tx_sh[7:1]};
                    n.tx_cnt = state_r[c].tx_cnt - 4'h1;
                end else if (q_valid[c] && !permit_n[c]) begin
                    bitv = q_data[c][0];
                    n.tx_sh = {1'b0, q_data[c][7:1]};
                    n.tx_cnt = LOAD_BITS;
                    pop[c] = 1'b1;
                end else begin
                    // Idle line marks ones between bytes
                    bitv = 1'b1;
                end
                n.tx_bit = bitv;
                n.tx_clk_tog = ~state_r[c].tx_clk_tog;
                case (cfg[c].coding)
                    CODE_NRZ: n.tx_line = bitv;
                    CODE_NRZI: n.tx_line = bitv ? state_r[c].tx_line : ~state_r[c].tx_line;
                    CODE_FM: n.tx_line = ~state_r[c].tx_line;
                    CODE_MAN: n.tx_line = ~bitv;
                    default: n.tx_line = bitv;
                endcase
            end else if (mid) begin
                n.tx_clk_tog = ~state_r[c].tx_clk_tog;
                if (cfg[c].coding == CODE_FM && !state_r[c].tx_bit) begin
                    n.tx_line = ~state_r[c].tx_line;
                end else if (cfg[c].coding == CODE_MAN) begin
                    n.tx_line = state_r[c].tx_bit;
                end
            end
            n.rts_n = ~(q_valid[c] | (state_r[c].tx_cnt != 4'h0));
            n.dtr_n = ~cfg[c].term_ready;

            // Receive sampling on rising edge of the pin clock
            samp = cfg[c].rx_pin_clk ? rx_rise : tick;
            dbit = 1'b0;
            if (samp) begin
                if (cfg[c].coding == CODE_FM || cfg[c].coding == CODE_MAN) begin
                    // Two samples a bit; half alignment is not recovered here
                    n.rx_phase = ~state_r[c].rx_phase;
                    if (!state_r[c].rx_phase) begin
                        n.rx_half = rxd[c];
                    end else begin
                        bit_ev[c] = 1'b1;
                        dbit = (cfg[c].coding == CODE_FM) ? (state_r[c].rx_half == rxd[c]) : rxd[c];
                    end
                end else begin
                    bit_ev[c] = 1'b1;
                    dbit = (cfg[c].coding == CODE_NRZI) ? (rxd[c] == state_r[c].rx_prev) : rxd[c];
                    n.rx_prev = rxd[c];
                end
            end
            n.rx_valid = 1'b0;
            if (bit_ev[c] && !carrier_n[c]) begin
                n.hist = {dbit, state_r[c].hist[7:1]};
                n.rx_sh = {dbit, state_r[c].rx_sh[7:1]};
                n.sync_n = 1'b1;
                if (n.hist == FLAG_OCTET) begin
                    // Flag also realigns byte boundaries
                    flag_hit[c] = 1'b1;
                    n.sync_n = 1'b0;
                    n.rx_cnt = 3'h0;
                end else begin
                    n.rx_cnt = state_r[c].rx_cnt + 3'h1;
                    if (state_r[c].rx_cnt == LAST_BIT) begin
                        n.rx_byte = n.rx_sh;
                        n.rx_valid = 1'b1;
                    end
                end
            end
            if (carrier_n[c]) begin
                n.rx_sh = '0;
                n.rx_cnt = '0;
                n.rx_phase = 1'b0;
                n.hist = '0;
                n.sync_n = 1'b1;
                n.rx_valid = 1'b0;
                // Last byte handed over stays in rx_byte
            end

            // Change latches; a new edge beats a clear in the same cycle
            n.cts_q = permit_n[c];
            n.dcd_q = carrier_n[c];
            n.chg.permit = (state_r[c].chg.permit & ~clr[c].permit) | (permit_n[c] ^ state_r[c].cts_q);
            n.chg.carrier = (state_r[c].chg.carrier & ~clr[c].carrier)
                | (carrier_n[c] ^ state_r[c].dcd_q);

            // Clock monitor on the transmit clock pin when not an input
            n.txc_oe = ~cfg[c].tx_clk_ext & cfg[c].mon_en;
            case (cfg[c].mon_sel)
                MON_TX: n.txc_o = state_r[c].tx_clk_tog;
                MON_RX: n.txc_o = state_r[c].rxc_q;
                MON_BAUD: n.txc_o = state_r[c].baud_tog;
                default: n.txc_o = 1'b0;
            endcase
            state_nxt[c] = n;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < NCH; c++) begin
                state_r[c] <= CHAN_RST;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                state_r[c] <= state_nxt[c];
            end
        end
    end

    // ==========================================================
    // Outputs, all from flops
    assign tx_ready_a = wr_ready[0];
    assign tx_ready_b = wr_ready[1];
    assign rx_byte_a = state_r[0].rx_byte;
    assign rx_byte_b = state_r[1].rx_byte;
    assign rx_valid_a = state_r[0].rx_valid;
    assign rx_valid_b = state_r[1].rx_valid;
    assign changed_a = state_r[0].chg;
    assign changed_b = state_r[1].chg;
    assign line_tx_data_a = state_r[0].tx_line;
    assign line_tx_data_b = state_r[1].tx_line;
    assign terminal_ready_n_a = state_r[0].dtr_n;
    assign terminal_ready_n_b = state_r[1].dtr_n;
    assign send_request_n_a = state_r[0].rts_n;
    assign send_request_n_b = state_r[1].rts_n;
    assign flag_seen_n_a = state_r[0].sync_n;
    assign flag_seen_n_b = state_r[1].sync_n;
    assign line_tx_clock_a_o = state_r[0].txc_o;
    assign line_tx_clock_b_o = state_r[1].txc_o;
    assign line_tx_clock_a_oe = state_r[0].txc_oe;
    assign line_tx_clock_b_oe = state_r[1].txc_oe;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        sequence s_flag_taken;
            bit_ev[g] && flag_hit[g] && !carrier_n[g];
        endsequence
        sequence s_flag_pulse;
            !state_r[g].sync_n && state_r[g].rx_cnt == 3'h0;
        endsequence
        property p_rts_low;
            q_valid[g] |=> !state_r[g].rts_n;
        endproperty
        a_rts_low: assert property (p_rts_low) else $error("send request not low with queued data");
        property p_rts_high;
            !q_valid[g] && state_r[g].tx_cnt == 4'h0 |=> state_r[g].rts_n;
        endproperty
        a_rts_high: assert property (p_rts_high) else $error("send request low with nothing to send");
        property p_pop_permit;
            pop[g] |-> !permit_n[g] ##1 state_r[g].tx_cnt == LOAD_BITS;
        endproperty
        a_pop_permit: assert property (p_pop_permit) else $error("byte loaded without send permit");
        property p_permit_chg;
            permit_n[g] != state_r[g].cts_q |=> state_r[g].chg.permit;
        endproperty
        a_permit_chg: assert property (p_permit_chg) else $error("send permit change not latched");
        property p_carrier_chg;
            $changed(carrier_n[g]) |-> ##1 state_r[g].chg.carrier;
        endproperty
        a_carrier_chg: assert property (p_carrier_chg) else $error("carrier change not latched");
        property p_carrier_hold;
            carrier_n[g] |=> state_r[g].rx_cnt == 3'h0 && state_r[g].rx_sh == 8'h00 && !state_r[g].rx_valid;
        endproperty
        a_carrier_hold: assert property (p_carrier_hold) else $error("receive shifter ran without carrier");
        property p_carrier_keep;
            carrier_n[g] |=> $stable(state_r[g].rx_byte);
        endproperty
        a_carrier_keep: assert property (p_carrier_keep) else $error("received byte lost on carrier loss");
        property p_flag_pulse;
            s_flag_taken |=> s_flag_pulse;
        endproperty
        a_flag_pulse: assert property (p_flag_pulse) else $error("flag did not pull flag seen low");
        property p_flag_width;
            !state_r[g].sync_n && !bit_ev[g] && !carrier_n[g] |=> !state_r[g].sync_n;
        endproperty
        a_flag_width: assert property (p_flag_width) else $error("flag seen pulse ended early");
        property p_nrz_out;
            b0_ev[g] && cfg[g].coding == CODE_NRZ |=> state_r[g].tx_line == state_r[g].tx_bit;
        endproperty
        a_nrz_out: assert property (p_nrz_out) else $error("NRZ line does not follow bit");
        property p_dtr;
            cfg[g].term_ready |=> !state_r[g].dtr_n;
        endproperty
        a_dtr: assert property (p_dtr) else $error("terminal ready not driven low");
        property p_txc_input;
            cfg[g].tx_clk_ext |=> !state_r[g].txc_oe;
        endproperty
        a_txc_input: assert property (p_txc_input) else $error("transmit clock pin driven while input");
    end
endmodule

// *** test/hlif_modem_model.sv ***
// Modem stand-in for one channel: permit, carrier, receive data and clock.
// Assumes the bench calls its tasks just after a core_clk rising edge.
`timescale 1ns/1ps
module hlif_modem_model (
    // Clock
    input wire logic core_clk,
    // Line pins driven by the modem
    output logic permit_n,
    output logic carrier_n,
    output logic rx_data,
    output logic rx_clock
);
    // ==========
    // Pin control
    task automatic set_pins(input logic p, input logic c);
        permit_n = p;
        carrier_n = c;
    endtask

    // ==========
    // One NRZ byte, LSB first, six core cycles a bit
    // Clock stands low between frames; data left inverted so nothing stale shows
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            rx_clock = 1'h0;
            rx_data = b[i];
            repeat (3) @(posedge core_clk);
            #1 rx_clock = 1'h1;
            repeat (3) @(posedge core_clk);
            #1;
        end
        rx_clock = 1'h0;
        rx_data = ~b[7];
    endtask

    initial begin
        set_pins(1'h1, 1'h1);
        rx_data = 1'h0;
        rx_clock = 1'h0;
    end
endmodule

// *** test/hlif_line_top_tb.sv ***
// Self-checking bench for the two-channel line interface.
// Assumes a modem model per channel; both channels get the same stimulus.
`timescale 1ns/1ps
module hlif_line_top_tb import hlif_pkg::*;;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    hlif_cfg_s cfg = '0;
    hlif_chg_s clr = '0;
    hlif_chg_s changed_a, changed_b;
    logic [7:0] txb = 8'h00;
    logic txv = 1'h0;
    logic txc_in = 1'h1;
    logic txo_a, txo_b, txoe_a, txoe_b;
    logic [7:0] rx_byte_a, rx_byte_b;
    logic tx_ready_a, tx_ready_b, rx_valid_a, rx_valid_b;
    logic line_tx_data_a, line_tx_data_b, terminal_ready_n_a, terminal_ready_n_b;
    logic send_request_n_a, send_request_n_b, flag_seen_n_a, flag_seen_n_b;
    logic send_permit_n_a, send_permit_n_b, carrier_present_n_a, carrier_present_n_b;
    logic line_rx_data_a, line_rx_data_b, line_rx_clock_a, line_rx_clock_b;
    int miscompares = 0;
    int compares = 0;
    int cyc = 0;
    int flow_a = 0;
    int flow_b = 0;
    int nval_a = 0;

    // ==========
    // Design and partners
    hlif_line_top #(.BAUD_DIV(8'h02)) dut (.core_clk, .rst, .cfg_a(cfg), .tx_byte_a(txb),
        .tx_valid_a(txv), .tx_ready_a, .rx_byte_a, .rx_valid_a, .changed_a, .change_clear_a(clr),
        .line_tx_data_a, .line_rx_data_a, .terminal_ready_n_a, .send_request_n_a, .send_permit_n_a,
        .carrier_present_n_a, .flag_seen_n_a, .line_rx_clock_a, .line_tx_clock_a_i(txc_in),
        .line_tx_clock_a_o(txo_a), .line_tx_clock_a_oe(txoe_a), .cfg_b(cfg), .tx_byte_b(txb), .tx_valid_b(txv),
        .tx_ready_b, .rx_byte_b, .rx_valid_b, .changed_b, .change_clear_b(clr), .line_tx_data_b,
        .line_rx_data_b, .terminal_ready_n_b, .send_request_n_b, .send_permit_n_b,
        .carrier_present_n_b, .flag_seen_n_b, .line_rx_clock_b, .line_tx_clock_b_i(txc_in),
        .line_tx_clock_b_o(txo_b), .line_tx_clock_b_oe(txoe_b));
    hlif_modem_model ma (.core_clk, .permit_n(send_permit_n_a), .carrier_n(carrier_present_n_a),
        .rx_data(line_rx_data_a), .rx_clock(line_rx_clock_a));
    hlif_modem_model mb (.core_clk, .permit_n(send_permit_n_b), .carrier_n(carrier_present_n_b),
        .rx_data(line_rx_data_b), .rx_clock(line_rx_clock_b));

    // ==========
    // Clock, watch counters, timeout
    initial forever #5 core_clk = ~core_clk;
    // Counted on the falling edge so flop updates have landed
    always @(negedge core_clk) begin
        flow_a += !flag_seen_n_a;
        flow_b += !flag_seen_n_b;
        nval_a += rx_valid_a;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    // ==========
    // Shared helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic pins(input logic p, input logic c);
        ma.set_pins(p, c);
        mb.set_pins(p, c);
    endtask

    // Ready is read a step after the edge on the first try only; a retry reads it at the edge itself, racing the flop
    task automatic push(input logic [7:0] b);
        logic r;
        txb = b;
        txv = 1'h1;
        do begin
            r = tx_ready_a;
            @(posedge core_clk);
        end while (!r);
        #1 txv = 1'h0;
        // Idle cycle so valid never falls and rises in one step
        step(1);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Half-bit line levels for a byte, from the line level before it
    function automatic logic [15:0] coded(input int c, input logic [7:0] b, input logic l);
        logic [15:0] h;
        for (int i = 0; i < 8; i++) begin
            case (c)
                0: h[2*i +: 2] = {2{b[i]}};
                1: begin
                    l ^= ~b[i];
                    h[2*i +: 2] = {2{l}};
                end
                2: begin
                    l = ~l;
                    h[2*i] = l;
                    l ^= ~b[i];
                    h[2*i+1] = l;
                end
                default: h[2*i +: 2] = {b[i], ~b[i]};
            endcase
        end
        return h;
    endfunction

    // ==========
    // Scenarios
    task automatic t_reset();
        check("txd_idle", line_tx_data_a, 1'h1);
        check("rts_idle", send_request_n_a, 1'h1);
        check("flag_idle", flag_seen_n_a, 1'h1);
        check("dtr_off", terminal_ready_n_a, 1'h1);
        cfg.term_ready = 1'h1;
        step(2);
        check("dtr_a", terminal_ready_n_a, 1'h0);
        check("dtr_b", terminal_ready_n_b, 1'h0);
    endtask

    // Queue fills while permit is withheld, then drains once granted
    task automatic t_fill();
        logic [1:0] m;
        cfg.mon_en = 1'h1;
        pins(1'h1, 1'h0);
        for (int i = 0; i < 4; i++)
            push(8'h10 + 8'(i));
        step(1);
        check("full_a", tx_ready_a, 1'h0);
        check("full_b", tx_ready_b, 1'h0);
        check("rts_wait", send_request_n_a, 1'h0);
        step(40);
        check("held_line", line_tx_data_a, 1'h1);
        check("mon_oe", {txoe_b, txoe_a}, 2'h3);
        m = {txo_b, txo_a};
        step(2);
        check("mon_tog", {txo_b, txo_a} ^ m, 2'h3);
        pins(1'h0, 1'h0);
        for (int n = 0; n < 400 && send_request_n_a !== 1'h1; n++)
            step(1);
        check("rts_done", send_request_n_a, 1'h1);
        check("ready_back", tx_ready_a, 1'h1);
        check("permit_seen", changed_a.permit, 1'h1);
        clr = '{permit: 1'h1, carrier: 1'h1};
        step(1);
        clr = '0;
        step(1);
        check("permit_clr", changed_a.permit, 1'h0);
    endtask

    // Every coding once; the bench clocks the transmitter through its pin
    task automatic t_coding();
        logic [15:0] sa, sb;
        logic [7:0] b;
        logic l;
        cfg.tx_clk_ext = 1'h1;
        for (int c = 0; c < 4; c++) begin
            cfg.coding = hlif_code_e'(c[1:0]);
            pins(1'h1, 1'h0);
            step(12);
            check("mon_off", txoe_a, 1'h0);
            l = line_tx_data_a;
            b = {7'h2D, (c == 0) ? ~l : (c == 3) ? l : 1'h0};
            push(b);
            step(4);
            check("rts_q", send_request_n_a, 1'h0);
            pins(1'h0, 1'h0);
            // Even steps fall for a bit boundary, odd steps rise for mid-bit
            for (int k = 0; k < 16; k++) begin
                txc_in = k[0];
                step(1);
                sa[k] = line_tx_data_a;
                sb[k] = line_tx_data_b;
            end
            check("coded_a", sa, coded(c, b, l));
            check("coded_b", sb, coded(c, b, l));
        end
    endtask

    task automatic t_receive();
        cfg.rx_pin_clk = 1'h1;
        cfg.coding = CODE_NRZ;
        // Carrier pulse first so the byte counter starts from zero
        pins(1'h0, 1'h1);
        step(2);
        pins(1'h0, 1'h0);
        step(1);
        clr.carrier = 1'h1;
        step(1);
        clr = '0;
        flow_a = 0;
        flow_b = 0;
        nval_a = 0;
        fork ma.send_byte(FLAG_OCTET); mb.send_byte(FLAG_OCTET); join
        fork ma.send_byte(8'h35); mb.send_byte(8'h35); join
        step(8);
        check("flag_len_a", 16'(flow_a), 16'h0006);
        check("flag_len_b", 16'(flow_b), 16'h0006);
        check("rx_count", 16'(nval_a), 16'h0001);
        check("rx_a", rx_byte_a, 8'h35);
        check("rx_b", rx_byte_b, 8'h35);
        check("dcd_quiet", changed_a.carrier, 1'h0);
        pins(1'h0, 1'h1);
        step(3);
        check("dcd_seen", changed_a.carrier, 1'h1);
        fork ma.send_byte(FLAG_OCTET); mb.send_byte(FLAG_OCTET); join
        fork ma.send_byte(8'hC3); mb.send_byte(8'hC3); join
        step(8);
        check("rx_blocked", 16'(nval_a), 16'h0001);
        check("rx_kept", rx_byte_a, 8'h35);
        check("flag_blocked", 16'(flow_a), 16'h0006);
    endtask

    // ==========
    // Main sequence
    initial begin
        step(3);
        rst = 1'h0;
        step(1);
        t_reset();
        t_fill();
        t_coding();
        t_receive();
        wrap_up();
    end
endmodule
